// file: rtl/pust_params.svh
`ifndef PUST_PARAMS_SVH
`define PUST_PARAMS_SVH

// clock and indicator timing
`define PUST_CLK_HZ 50000000
`define PUST_BLINK_ON_MS 200
`define PUST_BLINK_OFF_MS 200
`define PUST_BLINK_GAP_MS 1000
`define PUST_BLINK_ON_CYC (`PUST_BLINK_ON_MS * (`PUST_CLK_HZ / 1000))
`define PUST_BLINK_OFF_CYC (`PUST_BLINK_OFF_MS * (`PUST_CLK_HZ / 1000))
`define PUST_BLINK_GAP_CYC (`PUST_BLINK_GAP_MS * (`PUST_CLK_HZ / 1000))

// option switch bank
`define PUST_SW_WIDTH 8
`define PUST_SW_SELF_TEST_BIT 0
`define PUST_SYNC_FILL 2'h3

// ROM sockets: sixteen equal blocks, ascending
`define PUST_ROM_BASE 16'h8000
`define PUST_ROM_SIZE 16'h0800
`define PUST_ROM_SOCKETS 16
`define PUST_BOOT_SOCKET 4'hF
`define PUST_BUS_SOCK_FIRST 4'h4
`define PUST_BUS_SOCK_AFTER 4'hC
`define PUST_BUS_SOCK_COUNT 5'h08
`define PUST_HDR_ADDR_OFS 16'h0000
`define PUST_HDR_CKS_OFS 16'h0001
`define PUST_HDR_SUM_OFS 16'h0003

// RAM regions: main, bus board low pair, bus board high pair
`define PUST_RAM_MAIN_BASE 16'h0000
`define PUST_RAM_LOW_BASE 16'h0400
`define PUST_RAM_HIGH_BASE 16'h0800
`define PUST_RAM_REGION_SIZE 16'h0400
`define PUST_RAM_CHIP_SIZE 16'h0200
`define PUST_RAM_PAT_A 8'h55
`define PUST_RAM_PAT_B 8'hAA
`define PUST_RAM_LOW_CODE_OFS 5'h06
`define PUST_RAM_HIGH_CODE_OFS 5'h08

// parallel interface adapter, side A
`define PUST_PIA_CTRL_A 16'h4000
`define PUST_PIA_DDR_A 16'h4000
`define PUST_PIA_CTRL_A_ADDR 16'h4001
`define PUST_PIA_CTRL_TEST 8'h3B
`define PUST_PIA_CTRL_DDR_SEL 8'h00
`define PUST_PIA_CTRL_MASK 8'h3F
`define PUST_PIA_DDR_TEST 8'hA5
`define PUST_PIA_FULL_MASK 8'hFF

// talk/listen adapter
`define PUST_TLA_STATUS 16'h6000
`define PUST_TLA_ADDR_MODE 16'h6004
`define PUST_TLA_AUX_CMD 16'h6003
`define PUST_TLA_RESET_SET 8'h80
`define PUST_TLA_RESET_CLR 8'h00
`define PUST_TLA_LISTEN_ONLY 8'h40
`define PUST_TLA_TALK_ONLY 8'h80
`define PUST_TLA_TL_MASK 8'h06
`define PUST_TLA_LISTEN_BIT 8'h04
`define PUST_TLA_TALK_BIT 8'h02
`define PUST_TLA_NONE 8'h00
`define PUST_ADP_PIA_LAST 4'h4
`define PUST_ADP_LAST 4'hB

// indicator LED indices and failure codes
`define PUST_LED_COUNT 6
`define PUST_LED_BOOT 3'h0
`define PUST_LED_RAM 3'h1
`define PUST_LED_ROM 3'h2
`define PUST_LED_IBUS 3'h3
`define PUST_LED_HBUS 3'h4
`define PUST_LED_PASS 3'h5
`define PUST_CODE_ONE 5'h01

`endif

// file: rtl/pust_pkg.sv
package pust_pkg;

	typedef enum logic [3:0] {
		ST_STRAP, ST_NORMAL, ST_ROM_HDR0, ST_ROM_HDR1, ST_ROM_HDR3, ST_ROM_SUM, ST_ROM_NEXT,
		ST_RAM_WR, ST_RAM_RD, ST_RAM_NEXT, ST_ADP, ST_HALT
	} pust_state_e;

	typedef enum logic [1:0] {BL_ON, BL_OFF, BL_GAP} pust_blink_e;

	// one access on the processor bus
	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} pust_mem_s;

	// one adapter step: access, expected value and compare mask
	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [7:0] data;
		logic [7:0] mask;
	} pust_adp_op_s;

endpackage

// file: rtl/pust_sequencer.sv
`timescale 1ns/1ps
`include "pust_params.svh"
module pust_sequencer
	import pust_pkg::*;
#(
	parameter int unsigned BLINK_ON_CYC = `PUST_BLINK_ON_CYC,
	parameter int unsigned BLINK_OFF_CYC = `PUST_BLINK_OFF_CYC,
	parameter int unsigned BLINK_GAP_CYC = `PUST_BLINK_GAP_CYC
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [`PUST_SW_WIDTH-1:0] option_switch_bank,
	input wire logic bus_board_present,
	output logic mem_req,
	output logic mem_we,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	output logic normal_run,
	output logic test_active,
	output logic boot_rom_fail_led,
	output logic ram_fail_led,
	output logic rom_fail_led,
	output logic instrument_bus_fail_led,
	output logic host_bus_fail_led,
	output logic pass_led
);

	// ************************************************
	// strap capture
	// ************************************************
	logic [`PUST_SW_WIDTH:0] sync1_reg, sync2_reg, sync3_reg;
	logic [1:0] fill_reg;
	logic strap_done_reg;
	logic self_test_reg;
	logic board_reg;

	// three-stage sync; first stage is read only by the second
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
		end else begin
			sync1_reg <= {bus_board_present, option_switch_bank};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// latched once; later switch changes wait for the next power cycle
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			fill_reg <= 2'h0;
			strap_done_reg <= 1'b0;
			self_test_reg <= 1'b0;
			board_reg <= 1'b0;
		end else if (fill_reg != `PUST_SYNC_FILL) begin
			fill_reg <= fill_reg + 2'h1;
		end else if (!strap_done_reg && sync2_reg == sync3_reg) begin
			strap_done_reg <= 1'b1;
			self_test_reg <= sync3_reg[`PUST_SW_SELF_TEST_BIT];
			board_reg <= sync3_reg[`PUST_SW_WIDTH];
		end
	end

	// ************************************************
	// sequencer
	// ************************************************
	pust_state_e state_reg;
	pust_mem_s mem_reg;
	logic req_reg;
	logic boot_reg;
	logic [3:0] sock_reg;
	logic [15:0] ofs_reg;
	logic [7:0] sum_reg;
	logic [7:0] stored_reg;
	logic msb0_reg;
	logic [4:0] empty_reg;
	logic [1:0] region_reg;
	logic pat_b_reg;
	logic [1:0] chip_err_reg;
	logic [3:0] op_reg;
	logic [2:0] led_sel_reg;
	logic [4:0] code_reg;
	logic [15:0] rom_base;
	logic [15:0] ram_base;
	logic [3:0] sock_next;
	logic [7:0] sum_next;
	logic [7:0] pat;
	logic ram_last;
	pust_adp_op_s adp_op;

	assign rom_base = `PUST_ROM_BASE + {sock_reg, 11'h000};
	assign sum_next = sum_reg + mem_rdata;
	assign pat = pat_b_reg ? `PUST_RAM_PAT_B : `PUST_RAM_PAT_A;
	assign ram_last = (ofs_reg == `PUST_RAM_REGION_SIZE - 16'h0001);

	// RAM region base and next socket, bus board sockets skipped when absent
	always_comb begin
		unique case (region_reg)
			2'h0: ram_base = `PUST_RAM_MAIN_BASE;
			2'h1: ram_base = `PUST_RAM_LOW_BASE;
			default: ram_base = `PUST_RAM_HIGH_BASE;
		endcase
		sock_next = sock_reg + 4'h1;
		if (!board_reg && sock_next == `PUST_BUS_SOCK_FIRST) begin
			sock_next = `PUST_BUS_SOCK_AFTER;
		end
	end

	// adapter step table
	always_comb begin
		adp_op = '0;
		unique case (op_reg)
			4'h0: adp_op = {1'b1, `PUST_PIA_CTRL_A_ADDR, `PUST_PIA_CTRL_TEST, 8'h00};
			4'h1: adp_op = {1'b0, `PUST_PIA_CTRL_A_ADDR, `PUST_PIA_CTRL_TEST, `PUST_PIA_CTRL_MASK};
			4'h2: adp_op = {1'b1, `PUST_PIA_CTRL_A_ADDR, `PUST_PIA_CTRL_DDR_SEL, 8'h00};
			4'h3: adp_op = {1'b1, `PUST_PIA_DDR_A, `PUST_PIA_DDR_TEST, 8'h00};
			4'h4: adp_op = {1'b0, `PUST_PIA_DDR_A, `PUST_PIA_DDR_TEST, `PUST_PIA_FULL_MASK};
			4'h5: adp_op = {1'b1, `PUST_TLA_AUX_CMD, `PUST_TLA_RESET_SET, 8'h00};
			4'h6: adp_op = {1'b1, `PUST_TLA_AUX_CMD, `PUST_TLA_RESET_CLR, 8'h00};
			4'h7: adp_op = {1'b0, `PUST_TLA_STATUS, `PUST_TLA_NONE, `PUST_TLA_TL_MASK};
			4'h8: adp_op = {1'b1, `PUST_TLA_ADDR_MODE, `PUST_TLA_LISTEN_ONLY, 8'h00};
			4'h9: adp_op = {1'b0, `PUST_TLA_STATUS, `PUST_TLA_LISTEN_BIT, `PUST_TLA_TL_MASK};
			4'hA: adp_op = {1'b1, `PUST_TLA_ADDR_MODE, `PUST_TLA_TALK_ONLY, 8'h00};
			default: adp_op = {1'b0, `PUST_TLA_STATUS, `PUST_TLA_TALK_BIT, `PUST_TLA_TL_MASK};
		endcase
	end

	// step walk; all test state lives in flops so a bad RAM cannot upset it
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_reg <= ST_STRAP;
			mem_reg <= '0;
			req_reg <= 1'b0;
			boot_reg <= 1'b1;
			sock_reg <= `PUST_BOOT_SOCKET;
			ofs_reg <= 16'h0000;
			sum_reg <= 8'h00;
			stored_reg <= 8'h00;
			msb0_reg <= 1'b0;
			empty_reg <= 5'h00;
			region_reg <= 2'h0;
			pat_b_reg <= 1'b0;
			chip_err_reg <= 2'h0;
			op_reg <= 4'h0;
			led_sel_reg <= `PUST_LED_PASS;
			code_reg <= `PUST_CODE_ONE;
		end else begin
			unique case (state_reg)
				ST_STRAP: begin
					if (strap_done_reg) begin
						state_reg <= self_test_reg ? ST_ROM_HDR0 : ST_NORMAL;
					end
				end
				ST_NORMAL: begin
					state_reg <= ST_NORMAL;
				end
				// header: first location carries the upper address byte
				ST_ROM_HDR0: begin
					if (!req_reg) begin
						req_reg <= 1'b1;
						mem_reg <= {1'b0, rom_base + `PUST_HDR_ADDR_OFS, 8'h00};
					end else if (mem_ack) begin
						req_reg <= 1'b0;
						sum_reg <= mem_rdata;
						msb0_reg <= mem_rdata[7];
						state_reg <= ST_ROM_HDR1;
					end
				end
				ST_ROM_HDR1: begin
					if (!req_reg) begin
						req_reg <= 1'b1;
						mem_reg <= {1'b0, rom_base + `PUST_HDR_CKS_OFS, 8'h00};
					end else if (mem_ack) begin
						req_reg <= 1'b0;
						stored_reg <= mem_rdata;
						state_reg <= ST_ROM_HDR3;
					end
				end
				ST_ROM_HDR3: begin
					if (!req_reg) begin
						req_reg <= 1'b1;
						mem_reg <= {1'b0, rom_base + `PUST_HDR_SUM_OFS, 8'h00};
					end else if (mem_ack) begin
						req_reg <= 1'b0;
						if (!boot_reg && msb0_reg && mem_rdata[7]) begin
							empty_reg <= empty_reg + 5'h01;
							state_reg <= ST_ROM_NEXT;
						end else begin
							sum_reg <= sum_next;
							ofs_reg <= `PUST_HDR_SUM_OFS + 16'h0001;
							state_reg <= ST_ROM_SUM;
						end
					end
				end
				ST_ROM_SUM: begin
					if (!req_reg) begin
						req_reg <= 1'b1;
						mem_reg <= {1'b0, rom_base + ofs_reg, 8'h00};
					end else if (mem_ack) begin
						req_reg <= 1'b0;
						sum_reg <= sum_next;
						ofs_reg <= ofs_reg + 16'h0001;
						if (ofs_reg == `PUST_ROM_SIZE - 16'h0001) begin
							if (sum_next != stored_reg) begin
								state_reg <= ST_HALT;
								led_sel_reg <= boot_reg ? `PUST_LED_BOOT : `PUST_LED_ROM;
								code_reg <= boot_reg ? `PUST_CODE_ONE :
									(sock_reg < `PUST_BUS_SOCK_FIRST ? {1'b0, sock_reg} + 5'h01 :
									{1'b0, sock_reg} + 5'h02);
							end else begin
								state_reg <= ST_ROM_NEXT;
							end
						end
					end
				end
				ST_ROM_NEXT: begin
					ofs_reg <= 16'h0000;
					if (boot_reg) begin
						boot_reg <= 1'b0;
						state_reg <= ST_RAM_WR;
					end else if (sock_reg == `PUST_BOOT_SOCKET) begin
						op_reg <= 4'h0;
						state_reg <= ST_ADP;
					end else begin
						sock_reg <= sock_next;
						state_reg <= ST_ROM_HDR0;
					end
				end
				// write then read back each location, pattern A then B
				ST_RAM_WR: begin
					if (!req_reg) begin
						req_reg <= 1'b1;
						mem_reg <= {1'b1, ram_base + ofs_reg, pat};
					end else if (mem_ack) begin
						req_reg <= 1'b0;
						state_reg <= ST_RAM_RD;
					end
				end
				ST_RAM_RD: begin
					if (!req_reg) begin
						req_reg <= 1'b1;
						mem_reg <= {1'b0, ram_base + ofs_reg, 8'h00};
					end else if (mem_ack) begin
						req_reg <= 1'b0;
						if (mem_rdata != pat) begin
							if (ofs_reg < `PUST_RAM_CHIP_SIZE) begin
								chip_err_reg[0] <= 1'b1;
							end else begin
								chip_err_reg[1] <= 1'b1;
							end
						end
						pat_b_reg <= !pat_b_reg;
						if (pat_b_reg) begin
							ofs_reg <= ofs_reg + 16'h0001;
							state_reg <= ram_last ? ST_RAM_NEXT : ST_RAM_WR;
						end else begin
							state_reg <= ST_RAM_WR;
						end
					end
				end
				// whole region scanned so a both-chips failure is reported
				ST_RAM_NEXT: begin
					ofs_reg <= 16'h0000;
					if (chip_err_reg != 2'h0) begin
						state_reg <= ST_HALT;
						led_sel_reg <= `PUST_LED_RAM;
						unique case (region_reg)
							2'h0: code_reg <= {3'h0, chip_err_reg};
							2'h1: code_reg <= {3'h0, chip_err_reg} + `PUST_RAM_LOW_CODE_OFS;
							default: code_reg <= {3'h0, chip_err_reg} + `PUST_RAM_HIGH_CODE_OFS;
						endcase
					end else if (board_reg && region_reg != 2'h2) begin
						region_reg <= region_reg + 2'h1;
						state_reg <= ST_RAM_WR;
					end else begin
						sock_reg <= 4'h0;
						empty_reg <= board_reg ? 5'h00 : `PUST_BUS_SOCK_COUNT;
						state_reg <= ST_ROM_HDR0;
					end
				end
				ST_ADP: begin
					if (!req_reg) begin
						req_reg <= 1'b1;
						mem_reg <= {adp_op.we, adp_op.addr, adp_op.data};
					end else if (mem_ack) begin
						req_reg <= 1'b0;
						op_reg <= op_reg + 4'h1;
						if (!adp_op.we && ((mem_rdata ^ adp_op.data) & adp_op.mask) != 8'h00) begin
							state_reg <= ST_HALT;
							led_sel_reg <= (op_reg <= `PUST_ADP_PIA_LAST) ? `PUST_LED_IBUS : `PUST_LED_HBUS;
							code_reg <= `PUST_CODE_ONE;
						end else if (op_reg == `PUST_ADP_LAST ||
							(op_reg == `PUST_ADP_PIA_LAST && !board_reg)) begin
							state_reg <= ST_HALT;
							led_sel_reg <= `PUST_LED_PASS;
							code_reg <= empty_reg + 5'h01;
						end
					end
				end
				default: begin
					state_reg <= ST_HALT;
				end
			endcase
		end
	end

	assign mem_req = req_reg;
	assign mem_we = mem_reg.we;
	assign mem_addr = mem_reg.addr;
	assign mem_wdata = mem_reg.wdata;

	// ************************************************
	// indicator blinker
	// ************************************************
	pust_blink_e blink_reg;
	logic [31:0] bcnt_reg;
	logic [4:0] left_reg;
	logic [`PUST_LED_COUNT-1:0] led_reg;
	logic run_reg;
	logic active_reg;

	// burst of code pulses, long gap, repeat; never leaves the halt state
	always_ff @(posedge clock) begin
		if (!rst_b || state_reg != ST_HALT) begin
			blink_reg <= BL_GAP;
			bcnt_reg <= 32'h0000_0001;
			left_reg <= 5'h00;
		end else if (bcnt_reg != 32'h0000_0001) begin
			bcnt_reg <= bcnt_reg - 32'h0000_0001;
		end else begin
			unique case (blink_reg)
				BL_ON: begin
					blink_reg <= BL_OFF;
					bcnt_reg <= BLINK_OFF_CYC;
				end
				BL_OFF: begin
					if (left_reg == 5'h00) begin
						blink_reg <= BL_GAP;
						bcnt_reg <= BLINK_GAP_CYC;
					end else begin
						blink_reg <= BL_ON;
						bcnt_reg <= BLINK_ON_CYC;
						left_reg <= left_reg - 5'h01;
					end
				end
				BL_GAP: begin
					blink_reg <= BL_ON;
					bcnt_reg <= BLINK_ON_CYC;
					left_reg <= code_reg - 5'h01;
				end
			endcase
		end
	end

	// registered indicator and mode outputs
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			led_reg <= '0;
			run_reg <= 1'b0;
			active_reg <= 1'b0;
		end else begin
			led_reg <= '0;
			if (state_reg == ST_HALT && blink_reg == BL_ON) begin
				led_reg[led_sel_reg] <= 1'b1;
			end
			run_reg <= (state_reg == ST_NORMAL);
			active_reg <= (state_reg != ST_NORMAL && state_reg != ST_STRAP);
		end
	end

	assign boot_rom_fail_led = led_reg[`PUST_LED_BOOT];
	assign ram_fail_led = led_reg[`PUST_LED_RAM];
	assign rom_fail_led = led_reg[`PUST_LED_ROM];
	assign instrument_bus_fail_led = led_reg[`PUST_LED_IBUS];
	assign host_bus_fail_led = led_reg[`PUST_LED_HBUS];
	assign pass_led = led_reg[`PUST_LED_PASS];
	assign normal_run = run_reg;
	assign test_active = active_reg;

endmodule

// file: tb/pust_mem_model.sv
`timescale 1ns/1ps
// ****
// ROM, RAM and adapter model
// ****
module pust_mem_model
	import pust_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic mem_ack,
	output logic [7:0] mem_rdata,
	input wire logic slow,
	input wire logic [15:0] rom_empty,
	input wire logic [15:0] rom_bad,
	input wire logic [15:0] ram_bad0,
	input wire logic [15:0] ram_bad1,
	input wire logic pia_bad
);
	logic [7:0] ram [0:3071];
	logic [7:0] pia_ctrl_reg, pia_ddr_reg, tla_status_reg, idle_reg, rd_val;
	logic [1:0] cnt_reg;
	logic ack_reg;

	// header: socket upper byte, checksum, spare; filler 11 so CD is its sum
	function automatic logic [7:0] rom_byte(input logic [15:0] a);
		logic [7:0] hi;
		hi = a[15:8] & 8'hF8;
		if (rom_empty[a[14:11]]) return 8'hFF;
		case (a[10:0])
			11'h000: return hi;
			11'h001: return (hi + 8'hCD) ^ {7'h00, rom_bad[a[14:11]]};
			11'h002: return 8'h00;
			default: return 8'h11;
		endcase
	endfunction

	// read mux; stuck bit 7 only bites the AA pattern
	always_comb begin
		if (mem_addr[15]) rd_val = rom_byte(mem_addr);
		else if (mem_addr < 16'h0C00) rd_val = ram[mem_addr[11:0]] & ((mem_addr == ram_bad0 || mem_addr == ram_bad1) ? 8'h7F : 8'hFF);
		else if (mem_addr == 16'h4001) rd_val = pia_ctrl_reg ^ {7'h00, pia_bad};
		else if (mem_addr == 16'h4000) rd_val = pia_ddr_reg;
		else if (mem_addr == 16'h6000) rd_val = tla_status_reg;
		else rd_val = ~idle_reg;
	end

	// prompt answers in the request cycle, slow ones two cycles later
	assign mem_ack = slow ? ack_reg : mem_req;
	assign mem_rdata = mem_ack ? rd_val : idle_reg;

	// ack timing and an idle pattern that never settles
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ack_reg <= 1'h0;
			cnt_reg <= 2'h0;
			idle_reg <= 8'h5A;
		end else begin
			ack_reg <= mem_req && !ack_reg && cnt_reg == 2'h1;
			cnt_reg <= (mem_req && !ack_reg) ? cnt_reg + 2'h1 : 2'h0;
			idle_reg <= ~idle_reg;
		end
	end

	// RAM cells, no reset as on real parts
	always_ff @(posedge clock) begin
		if (mem_req && mem_ack && mem_we && mem_addr < 16'h0C00) ram[mem_addr[11:0]] <= mem_wdata;
	end

	// adapter registers; status starts dirty so a skipped reset is seen
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pia_ctrl_reg <= 8'h00;
			pia_ddr_reg <= 8'h00;
			tla_status_reg <= 8'h06;
		end else if (mem_req && mem_ack && mem_we) begin
			if (mem_addr == 16'h4001) pia_ctrl_reg <= mem_wdata & 8'h3F;
			if (mem_addr == 16'h4000) pia_ddr_reg <= mem_wdata;
			if (mem_addr == 16'h6003 && mem_wdata[7]) tla_status_reg <= 8'h00;
			if (mem_addr == 16'h6004) tla_status_reg <= {5'h00, mem_wdata[6], mem_wdata[7], 1'h0};
		end
	end
endmodule

// file: tb/pust_monitor.sv
`timescale 1ns/1ps
`include "pust_params.svh"
// ****
// sequencer port checker
// ****
module pust_monitor
	import pust_pkg::*;
#(
	parameter int unsigned BLINK_ON_CYC = 4,
	parameter int unsigned BLINK_OFF_CYC = 3,
	parameter int unsigned BLINK_GAP_CYC = 20
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [`PUST_SW_WIDTH-1:0] option_switch_bank,
	input wire logic bus_board_present,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	input wire logic normal_run,
	input wire logic test_active,
	input wire logic boot_rom_fail_led,
	input wire logic ram_fail_led,
	input wire logic rom_fail_led,
	input wire logic instrument_bus_fail_led,
	input wire logic host_bus_fail_led,
	input wire logic pass_led
);
	logic [5:0] leds;
	logic wr_seen_reg, stop_reg;
	logic [15:0] last_w_reg;
	logic [3:0] sock_reg;
	assign leds = {pass_led, host_bus_fail_led, instrument_bus_fail_led, rom_fail_led, ram_fail_led, boot_rom_fail_led};

	// sticky flags; stop stays set through the dark part of a blink
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			wr_seen_reg <= 1'h0;
			stop_reg <= 1'h0;
		end else begin
			if (mem_req && mem_we) wr_seen_reg <= 1'h1;
			if (leds != 6'h00) stop_reg <= 1'h1;
		end
	end

	// last written address, last socket read once writes began
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			last_w_reg <= 16'h0000;
			sock_reg <= 4'h0;
		end else begin
			if (mem_req && mem_we && mem_ack) last_w_reg <= mem_addr;
			if (mem_req && !mem_we && mem_addr[15] && wr_seen_reg) sock_reg <= mem_addr[14:11];
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence s_wr55;
		mem_req && mem_we && mem_ack && mem_wdata == 8'h55 && mem_addr < 16'h0C00;
	endsequence
	sequence s_wraa;
		mem_req && mem_we && mem_ack && mem_wdata == 8'hAA && mem_addr == last_w_reg;
	endsequence

	AST_NORMAL_QUIET: assert property (normal_run |-> !mem_req && !test_active)
		else $error("normal mode started a test");
	AST_SWITCH_ONCE: assert property ((normal_run || test_active) |=> $stable(normal_run))
		else $error("mode changed after capture");
	AST_BOOT_ONLY: assert property (mem_req && !mem_we && !wr_seen_reg |-> mem_addr[15:11] == 5'h1F)
		else $error("first step left the boot ROM");
	AST_FIRST_WRITE: assert property (
		mem_req && mem_we && !wr_seen_reg |-> mem_addr == 16'h0000 && mem_wdata == 8'h55)
		else $error("RAM step did not start at its base");
	AST_RAM_SECOND: assert property (s_wr55 |=> ##[1:16] s_wraa)
		else $error("complement pattern missing");
	AST_READ_LAST: assert property (
		mem_req && !mem_we && mem_addr < 16'h0C00 |-> mem_addr == last_w_reg)
		else $error("RAM read not of the written cell");
	AST_ONE_LED: assert property ($onehot0(leds))
		else $error("more than one indicator lit");
	AST_STOP: assert property (stop_reg |-> !mem_req && test_active)
		else $error("access after the verdict");
	AST_ASCEND: assert property (
		mem_req && !mem_we && mem_addr[15] && wr_seen_reg |-> mem_addr[14:11] >= sock_reg)
		else $error("ROM sockets out of order");
	AST_BOARD_ONLY: assert property (mem_req && (mem_addr[15:12] == 4'h6
		|| (mem_addr[15] && mem_addr[14:11] >= 4'h4 && mem_addr[14:11] < 4'hC)
		|| (mem_addr >= 16'h0400 && mem_addr < 16'h0C00)) |-> bus_board_present)
		else $error("bus board touched while absent");
	AST_REQ_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
		else $error("request changed before ack");
endmodule

bind pust_sequencer pust_monitor #(.BLINK_ON_CYC(BLINK_ON_CYC), .BLINK_OFF_CYC(BLINK_OFF_CYC),
	.BLINK_GAP_CYC(BLINK_GAP_CYC)) u_monitor (.clock, .rst_b, .option_switch_bank, .bus_board_present,
	.mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .normal_run, .test_active,
	.boot_rom_fail_led, .ram_fail_led, .rom_fail_led, .instrument_bus_fail_led, .host_bus_fail_led, .pass_led);

// file: tb/power_up_self_test_sequencer_bench.sv
`timescale 1ns/1ps
// ****
// self-test sequencer bench
// ****
module power_up_self_test_sequencer_bench;
	localparam int ON = 4;
	localparam int OFF = 3;
	localparam int GAP = 20;
	logic clock, rst_b, bus_board_present, mem_req, mem_we, mem_ack, normal_run, test_active, slow, pia_bad;
	logic boot_rom_fail_led, ram_fail_led, rom_fail_led, instrument_bus_fail_led, host_bus_fail_led, pass_led;
	logic [7:0] option_switch_bank, mem_wdata, mem_rdata;
	logic [15:0] mem_addr, rom_empty, rom_bad, ram_bad0, ram_bad1;
	logic [5:0] leds;
	int fails = 0;
	int compares = 0;
	assign leds = {pass_led, host_bus_fail_led, instrument_bus_fail_led, rom_fail_led, ram_fail_led, boot_rom_fail_led};

	pust_sequencer #(.BLINK_ON_CYC(ON), .BLINK_OFF_CYC(OFF), .BLINK_GAP_CYC(GAP)) u_dut (.clock, .rst_b,
		.option_switch_bank, .bus_board_present, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
		.mem_rdata, .normal_run, .test_active, .boot_rom_fail_led, .ram_fail_led, .rom_fail_led,
		.instrument_bus_fail_led, .host_bus_fail_led, .pass_led);
	pust_mem_model u_mem (.clock, .rst_b, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
		.slow, .rom_empty, .rom_bad, .ram_bad0, .ram_bad1, .pia_bad);

	// 50 MHz clock
	initial begin
		clock = 1'h0;
		forever #10 clock = ~clock;
	end

	task automatic tally_and_finish();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic check(input bit ok, input string msg);
		compares++;
		if (!ok) begin
			fails++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask

	// fresh power-up: switches and faults are set while reset is held
	task automatic restart(input logic [7:0] sw, input logic brd, input logic slw, input logic [15:0] empty,
		input logic [15:0] bad, input logic [15:0] r0, input logic [15:0] r1, input logic parallel_interface_adapter);
		@(posedge clock);
		rst_b <= 1'h0;
		option_switch_bank <= sw;
		bus_board_present <= brd;
		slow <= slw;
		rom_empty <= empty;
		rom_bad <= bad;
		ram_bad0 <= r0;
		ram_bad1 <= r1;
		pia_bad <= parallel_interface_adapter;
		repeat (5) @(posedge clock);
		rst_b <= 1'h1;
	endtask

	// counts one burst; a long dark spell marks its end
	task automatic burst(input logic [5:0] which, output int n, output bit odd);
		int low;
		logic [5:0] prev;
		n = 0;
		low = 0;
		odd = 1'b0;
		prev = leds;
		for (int i = 0; i < 4000; i++) begin
			@(posedge clock);
			#1;
			if (leds !== 6'h00 && leds !== which) odd = 1'b1;
			if (leds === which && prev === 6'h00) n++;
			low = (leds === 6'h00) ? low + 1 : 0;
			prev = leds;
			if (n > 0 && low > OFF + 2) break;
		end
	endtask

	// skips the burst already under way, then judges two whole ones
	task automatic expect_blink(input logic [5:0] which, input int code);
		int n1;
		int n2;
		bit odd1;
		bit odd2;
		bit seen;
		seen = 1'b0;
		for (int i = 0; i < 40000 && !seen; i++) begin
			@(posedge clock);
			#1;
			seen = (leds !== 6'h00);
		end
		if (!seen) begin
			fails++;
			$display("MISMATCH %0t no indicator lit", $time);
			tally_and_finish();
		end
		burst(which, n1, odd1);
		burst(which, n1, odd1);
		burst(which, n2, odd2);
		check(n1 == code && n2 == code && !odd1 && !odd2, "wrong indicator or pulse count");
		check(mem_req === 1'h0 && test_active === 1'h1, "bus active after verdict");
	endtask

	task automatic s_normal();
		restart(8'h00, 1'h0, 1'h0, 16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF, 1'h0);
		repeat (20) @(posedge clock);
		option_switch_bank <= 8'h01;
		repeat (20) @(posedge clock);
		#1;
		check(normal_run === 1'h1 && test_active === 1'h0 && mem_req === 1'h0, "normal mode lost");
	endtask

	task automatic s_boot_fail();
		restart(8'h01, 1'h0, 1'h1, 16'h0000, 16'h8000, 16'hFFFF, 16'hFFFF, 1'h0);
		repeat (30) @(posedge clock);
		option_switch_bank <= 8'h00;
		expect_blink(6'h01, 1);
		check(normal_run === 1'h0, "switch read again");
	endtask

	task automatic s_ram_main();
		restart(8'h01, 1'h0, 1'h0, 16'h0000, 16'h0000, 16'h01FF, 16'h03FF, 1'h0);
		expect_blink(6'h02, 3);
	endtask

	task automatic s_ram_board();
		restart(8'h01, 1'h1, 1'h0, 16'h0000, 16'h0000, 16'h0600, 16'hFFFF, 1'h0);
		expect_blink(6'h02, 8);
	endtask

	task automatic s_rom_order();
		restart(8'h01, 1'h0, 1'h0, 16'h000F, 16'h3000, 16'hFFFF, 16'hFFFF, 1'h0);
		expect_blink(6'h04, 14);
	endtask

	task automatic s_pia_fail();
		restart(8'h01, 1'h0, 1'h0, 16'h700F, 16'h0000, 16'hFFFF, 16'hFFFF, 1'h1);
		expect_blink(6'h08, 1);
	endtask

	task automatic s_pass();
		restart(8'h01, 1'h0, 1'h0, 16'h700F, 16'h0000, 16'hFFFF, 16'hFFFF, 1'h0);
		expect_blink(6'h20, 16);
	endtask

	// board fitted: talk/listen checks run, bus sockets counted as found empty
	task automatic s_board_pass();
		restart(8'h01, 1'h1, 1'h0, 16'h7FFF, 16'h0000, 16'hFFFF, 16'hFFFF, 1'h0);
		expect_blink(6'h20, 16);
	endtask

	// main sequence
	initial begin
		rst_b = 1'h0;
		option_switch_bank = 8'h00;
		bus_board_present = 1'h0;
		slow = 1'h0;
		rom_empty = 16'h0000;
		rom_bad = 16'h0000;
		ram_bad0 = 16'hFFFF;
		ram_bad1 = 16'hFFFF;
		pia_bad = 1'h0;
		s_normal();
		s_boot_fail();
		s_ram_main();
		s_ram_board();
		s_rom_order();
		s_pia_fail();
		s_pass();
		s_board_pass();
		tally_and_finish();
	end
endmodule
